// ### include/ssb_map.svh
// Register map, reset values, ranges and timing constants of the stop and brake sequencer
`ifndef SSB_MAP_SVH
`define SSB_MAP_SVH

// Register indices; byte address is four times the index
`define SSB_IDX_FAULT2 8'h07
`define SSB_IDX_OVT 8'h08
`define SSB_IDX_FAULT1 8'h09
`define SSB_IDX_PON 8'h0A
`define SSB_IDX_STILL 8'h0B
`define SSB_IDX_THR 8'h0C
`define SSB_IDX_ROTDLY 8'h0D
`define SSB_IDX_DISP 8'h10
`define SSB_IDX_CTRL 8'h30
`define SSB_IDX_STAT 8'h31

// Reset values
`define SSB_RST_FAULT2 16'h0002
`define SSB_RST_OVT 16'h0001
`define SSB_RST_FAULT1 16'h0002
`define SSB_RST_PON 16'h00FA
`define SSB_RST_STILL 16'h0096
`define SSB_RST_THR 16'h001E
`define SSB_RST_ROTDLY 16'h01F4
`define SSB_RST_DISP 16'h0000
`define SSB_RST_CTRL 16'h0000

// Accepted write ranges (fault class two is signed)
`define SSB_MIN_FAULT2 -16'sd5
`define SSB_MAX_FAULT2 16'sd3
`define SSB_MAX_OVT 16'h0007
`define SSB_MAX_FAULT1 16'h0002
`define SSB_MAX_PON 16'h01F4
`define SSB_MIN_STILL 16'h0032
`define SSB_MAX_STILL 16'h03E8
`define SSB_MIN_THR 16'h0014
`define SSB_MAX_THR 16'h0BB8
`define SSB_MIN_ROTDLY 16'h0001
`define SSB_MAX_ROTDLY 16'h03E8
`define SSB_MAX_DISP 16'h0001

// Field position and overtravel ignore code
`define SSB_CTRL_BRAKE_EN 0
`define SSB_OVT_IGNORE 16'h0007

// Timing: clock period and one millisecond, in ns
`define SSB_CLK_PERIOD_NS 8
`define SSB_MS_NS 1000000
`define SSB_CYC_PER_MS (`SSB_MS_NS / `SSB_CLK_PERIOD_NS)

`endif

// ### include/ssb_pkg.sv
// Types of the stop and brake sequencer
package ssb_pkg;

  // Stop method while decelerating
  typedef enum logic [2:0] {
    SSB_M_NONE = 3'h0,
    SSB_M_COAST = 3'h1,
    SSB_M_ZERO = 3'h2,
    SSB_M_EMERG = 3'h3,
    SSB_M_QUICK = 3'h4,
    SSB_M_PROFILE = 3'h5,
    SSB_M_DYNBRK = 3'h6
  } ssb_method_t;

  // State held after the stop
  typedef enum logic [1:0] {
    SSB_H_RUN = 2'h0,
    SSB_H_DEENERG = 2'h1,
    SSB_H_DYNBRK = 2'h2,
    SSB_H_POSLOCK = 2'h3
  } ssb_hold_t;

  // Sequencer states, Gray along power-up, run, stop
  typedef enum logic [2:0] {
    SSB_S_OFF = 3'h0,
    SSB_S_POWERUP = 3'h1,
    SSB_S_RUN = 3'h3,
    SSB_S_ROT_WAIT = 3'h2,
    SSB_S_STILL_WAIT = 3'h6,
    SSB_S_STOPPING = 3'h7,
    SSB_S_HELD = 3'h5
  } ssb_state_t;

  // Stop plan: method then hold
  typedef struct packed {
    ssb_method_t method;
    ssb_hold_t hold;
  } ssb_stop_t;

  // Filtered pin bundle
  typedef struct packed {
    logic servo_en;
    logic ovt;
    logic fault1;
    logic fault2;
    logic fault3;
    logic [15:0] speed;
  } ssb_pins_t;

  // Software settings
  typedef struct packed {
    logic [15:0] fault2_sel;
    logic [15:0] ovt_sel;
    logic [15:0] fault1_sel;
    logic [15:0] pon_ms;
    logic [15:0] still_ms;
    logic [15:0] thr_rpm;
    logic [15:0] rot_ms;
    logic [15:0] disp_sel;
    logic [15:0] ctrl;
  } ssb_cfg_t;

  // Millisecond timer state
  typedef struct packed {
    logic [16:0] cyc;
    logic [15:0] ms;
    logic run;
    logic done;
  } ssb_tmr_state_t;

  // Whole state of the top module
  typedef struct packed {
    ssb_pins_t s1;
    ssb_pins_t s2;
    ssb_pins_t s3;
    ssb_pins_t pins;
    ssb_cfg_t cfg;
    ssb_state_t st;
    ssb_stop_t plan;
    logic brake;
    logic stage;
    logic ref_block;
    logic display;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ssb_top_state_t;

endpackage : ssb_pkg

// ### rtl/ssb_ms_timer.sv
// Millisecond delay timer: restarts on a start pulse, flags expiry
`timescale 1ns/1ps
module ssb_ms_timer #(
  parameter logic [16:0] CYC_PER_MS = 17'd125000
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic [15:0] limit_ms_in,
  output logic done_out
);

  // Limit is captured at start so later writes do not disturb a running wait
  logic [15:0] limit_reg;
  logic [15:0] limit_next;
  ssb_pkg::ssb_tmr_state_t state_reg;
  ssb_pkg::ssb_tmr_state_t state_next;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    state_next = state_reg;
    limit_next = limit_reg;
    if (start_in) begin
      // Fresh wait; zero limit expires at once
      state_next.cyc = 17'h00000;
      state_next.ms = 16'h0000;
      state_next.run = (limit_ms_in != 16'h0000);
      state_next.done = (limit_ms_in == 16'h0000);
      limit_next = limit_ms_in;
    end else if (state_reg.run) begin
      if (state_reg.cyc == CYC_PER_MS - 17'h00001) begin
        // One millisecond elapsed
        state_next.cyc = 17'h00000;
        state_next.ms = state_reg.ms + 16'h0001;
        if (state_reg.ms + 16'h0001 >= limit_reg) begin
          state_next.run = 1'b0;
          state_next.done = 1'b1;
        end
      end else begin
        state_next.cyc = state_reg.cyc + 17'h00001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= '0;
      limit_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      limit_reg <= limit_next;
    end
  end

  assign done_out = state_reg.done;

endmodule : ssb_ms_timer

// ### rtl/ssb_top.sv
// Stop mode selection and holding brake sequencing with an APB register file
// What this block does
// R01: Signed class-two stop selector, -5..3, default 2
// R02: Codes -5,-4,-3: zero, emergency, quick; dynamic brake
// R03: Code -2 profile ramp, -1 dynamic brake
// R04: Codes 0..3 coast, profile, quick, emergency; de-energize
// R05: Overtravel 0..7 default 1; codes 0,1,2
// R06: Overtravel 3,4 quick ramp; de-energize or lock
// R07: Overtravel 5,6 dynamic brake; 7 ignores overtravel
// R08: Host picks overtravel 1 or 4 vertically
// R09: Brake function forces overtravel quick ramp, lock
// R10: Class-one selector 0..2 default 2
// R11: Brake function forces class-one dynamic brake, de-energize
// R12: Brake function forces class-two quick ramp, dynamic brake
// R13: Power-on references blocked 0..500 ms after brake
// R14: Standstill de-energize 50..1000 ms after brake off
// R15: Rotating brake off below speed threshold 20..3000
// R16: Rotating brake off 1..1000 ms after disable
// R17: Rotating brake off on whichever comes first
// R18: Class-three fault display switch, 0 or 1
`timescale 1ns/1ps
`include "ssb_map.svh"
module ssb_top #(
  parameter logic [16:0] CYC_PER_MS = 17'(`SSB_CYC_PER_MS)
) (
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic SERVO_ENABLE_IN,
  input wire logic OVERTRAVEL_IN,
  input wire logic FAULT1_IN,
  input wire logic FAULT2_IN,
  input wire logic FAULT3_IN,
  input wire logic [15:0] MOTOR_SPEED_IN,
  output logic HOLDING_BRAKE_OUTPUT_OUT,
  output logic POWER_STAGE_ON_OUT,
  output logic REF_BLOCK_OUT,
  output logic [2:0] STOP_METHOD_OUT,
  output logic [1:0] HOLD_STATE_OUT,
  output logic FAULT_DISPLAY_OUT
);

  ssb_pkg::ssb_top_state_t r_reg; // All state
  ssb_pkg::ssb_top_state_t r_next; // Next state
  logic tmr_start; // Restart the delay timer
  logic [15:0] tmr_limit; // Delay in ms
  logic tmr_done; // Delay expired
  logic brake_en; // Brake output function enabled
  logic evt; // A stop event is pending
  logic ovt_live; // Overtravel not ignored
  logic still; // Motor at zero speed
  logic slow; // Speed below brake threshold
  logic wr_go; // APB write takes effect
  logic [7:0] idx; // Register index
  logic hit; // Mapped register
  logic [15:0] wd; // Write data, low half
  ssb_pkg::ssb_stop_t plan_new; // Plan for a new stop

  ////////////////////////////////////////////////////////////////////////////
  // Stop plan lookup; priority class one, class two, overtravel
  function automatic ssb_pkg::ssb_stop_t plan_of(input logic f1, input logic f2,
                                                 input ssb_pkg::ssb_cfg_t c,
                                                 input logic ben);
    ssb_pkg::ssb_stop_t p;
    p.method = ssb_pkg::SSB_M_COAST;
    p.hold = ssb_pkg::SSB_H_DEENERG;
    if (f1) begin
      // R11: forced class-one plan
      if (ben) begin
        p = '{ssb_pkg::SSB_M_DYNBRK, ssb_pkg::SSB_H_DEENERG};
      end else begin
        // R10: class-one codes
        unique case (c.fault1_sel[1:0])
          2'h1: p = '{ssb_pkg::SSB_M_DYNBRK, ssb_pkg::SSB_H_DEENERG};
          2'h2: p = '{ssb_pkg::SSB_M_DYNBRK, ssb_pkg::SSB_H_DYNBRK};
          default: p = '{ssb_pkg::SSB_M_COAST, ssb_pkg::SSB_H_DEENERG};
        endcase
      end
    end else if (f2) begin
      // R12: forced class-two plan
      if (ben) begin
        p = '{ssb_pkg::SSB_M_QUICK, ssb_pkg::SSB_H_DYNBRK};
      end else begin
        // R02 R03 R04: class-two codes
        unique case (c.fault2_sel[3:0])
          4'hB: p = '{ssb_pkg::SSB_M_ZERO, ssb_pkg::SSB_H_DYNBRK};
          4'hC: p = '{ssb_pkg::SSB_M_EMERG, ssb_pkg::SSB_H_DYNBRK};
          4'hD: p = '{ssb_pkg::SSB_M_QUICK, ssb_pkg::SSB_H_DYNBRK};
          4'hE: p = '{ssb_pkg::SSB_M_PROFILE, ssb_pkg::SSB_H_DYNBRK};
          4'hF: p = '{ssb_pkg::SSB_M_DYNBRK, ssb_pkg::SSB_H_DYNBRK};
          4'h1: p = '{ssb_pkg::SSB_M_PROFILE, ssb_pkg::SSB_H_DEENERG};
          4'h2: p = '{ssb_pkg::SSB_M_QUICK, ssb_pkg::SSB_H_DEENERG};
          4'h3: p = '{ssb_pkg::SSB_M_EMERG, ssb_pkg::SSB_H_DEENERG};
          default: p = '{ssb_pkg::SSB_M_COAST, ssb_pkg::SSB_H_DEENERG};
        endcase
      end
    end else if (ben) begin
      // R09: forced overtravel plan
      p = '{ssb_pkg::SSB_M_QUICK, ssb_pkg::SSB_H_POSLOCK};
    end else begin
      // R05 R06 R07: overtravel codes
      unique case (c.ovt_sel[2:0])
        3'h1: p = '{ssb_pkg::SSB_M_ZERO, ssb_pkg::SSB_H_POSLOCK};
        3'h2: p = '{ssb_pkg::SSB_M_ZERO, ssb_pkg::SSB_H_DEENERG};
        3'h3: p = '{ssb_pkg::SSB_M_QUICK, ssb_pkg::SSB_H_DEENERG};
        3'h4: p = '{ssb_pkg::SSB_M_QUICK, ssb_pkg::SSB_H_POSLOCK};
        3'h5: p = '{ssb_pkg::SSB_M_DYNBRK, ssb_pkg::SSB_H_DEENERG};
        3'h6: p = '{ssb_pkg::SSB_M_DYNBRK, ssb_pkg::SSB_H_DYNBRK};
        default: p = '{ssb_pkg::SSB_M_COAST, ssb_pkg::SSB_H_DEENERG};
      endcase
    end
    return p;
  endfunction : plan_of

  ////////////////////////////////////////////////////////////////////////////
  // Write range check; out-of-range writes are dropped
  function automatic logic wr_ok(input logic [7:0] i, input logic [15:0] d);
    logic ok;
    ok = 1'b1;
    unique case (i)
      // R01: signed class-two range
      `SSB_IDX_FAULT2: ok = ($signed(d) >= `SSB_MIN_FAULT2) && ($signed(d) <= `SSB_MAX_FAULT2);
      `SSB_IDX_OVT: ok = (d <= `SSB_MAX_OVT);
      `SSB_IDX_FAULT1: ok = (d <= `SSB_MAX_FAULT1);
      `SSB_IDX_PON: ok = (d <= `SSB_MAX_PON);
      `SSB_IDX_STILL: ok = (d >= `SSB_MIN_STILL) && (d <= `SSB_MAX_STILL);
      `SSB_IDX_THR: ok = (d >= `SSB_MIN_THR) && (d <= `SSB_MAX_THR);
      `SSB_IDX_ROTDLY: ok = (d >= `SSB_MIN_ROTDLY) && (d <= `SSB_MAX_ROTDLY);
      `SSB_IDX_DISP: ok = (d <= `SSB_MAX_DISP);
      default: ok = 1'b1;
    endcase
    return ok;
  endfunction : wr_ok

  ////////////////////////////////////////////////////////////////////////////
  // Shared delay timer
  ssb_ms_timer #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_timer (
    .clk_in(MCLK_IN),
    .rst_in(RST_IN),
    .start_in(tmr_start),
    .limit_ms_in(tmr_limit),
    .done_out(tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Derived conditions
  always_comb begin
    brake_en = r_reg.cfg.ctrl[`SSB_CTRL_BRAKE_EN];
    // R07: code 7 ignores overtravel
    ovt_live = r_reg.pins.ovt && (r_reg.cfg.ovt_sel != `SSB_OVT_IGNORE);
    evt = r_reg.pins.fault1 || r_reg.pins.fault2 || ovt_live;
    still = (r_reg.pins.speed == 16'h0000);
    slow = (r_reg.pins.speed < r_reg.cfg.thr_rpm);
    plan_new = plan_of(r_reg.pins.fault1, r_reg.pins.fault2, r_reg.cfg, brake_en);
    idx = PADDR_IN[9:2];
    wd = PWDATA_IN[15:0];
    hit = (PADDR_IN[1:0] == 2'h0) && (PADDR_IN[11:10] == 2'h0) &&
          (idx inside {`SSB_IDX_FAULT2, `SSB_IDX_OVT, `SSB_IDX_FAULT1, `SSB_IDX_PON,
                       `SSB_IDX_STILL, `SSB_IDX_THR, `SSB_IDX_ROTDLY, `SSB_IDX_DISP,
                       `SSB_IDX_CTRL, `SSB_IDX_STAT});
    wr_go = PSEL_IN && PENABLE_IN && r_reg.pready && PWRITE_IN && hit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state of everything
  always_comb begin
    r_next = r_reg;
    tmr_start = 1'b0;
    tmr_limit = 16'h0000;
    // Pins: three stages, a bit changes when stages two and three agree
    r_next.s1 = '{SERVO_ENABLE_IN, OVERTRAVEL_IN, FAULT1_IN, FAULT2_IN, FAULT3_IN, MOTOR_SPEED_IN};
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    r_next.pins = (r_reg.s2 & r_reg.s3) | (r_reg.pins & (r_reg.s2 | r_reg.s3));
    // APB: answer in the first access cycle
    r_next.pready = PSEL_IN && !PENABLE_IN;
    r_next.pslverr = PSEL_IN && !PENABLE_IN && !hit;
    if (PSEL_IN && !PENABLE_IN) begin
      // Capture read data at setup
      unique case (idx)
        `SSB_IDX_FAULT2: r_next.prdata = {16'h0000, r_reg.cfg.fault2_sel};
        `SSB_IDX_OVT: r_next.prdata = {16'h0000, r_reg.cfg.ovt_sel};
        `SSB_IDX_FAULT1: r_next.prdata = {16'h0000, r_reg.cfg.fault1_sel};
        `SSB_IDX_PON: r_next.prdata = {16'h0000, r_reg.cfg.pon_ms};
        `SSB_IDX_STILL: r_next.prdata = {16'h0000, r_reg.cfg.still_ms};
        `SSB_IDX_THR: r_next.prdata = {16'h0000, r_reg.cfg.thr_rpm};
        `SSB_IDX_ROTDLY: r_next.prdata = {16'h0000, r_reg.cfg.rot_ms};
        `SSB_IDX_DISP: r_next.prdata = {16'h0000, r_reg.cfg.disp_sel};
        `SSB_IDX_CTRL: r_next.prdata = {16'h0000, r_reg.cfg.ctrl};
        `SSB_IDX_STAT: r_next.prdata = {20'h00000, r_reg.st, r_reg.plan, r_reg.stage,
                                        r_reg.brake, r_reg.ref_block, r_reg.display};
        default: r_next.prdata = 32'h00000000;
      endcase
    end
    // Register writes
    if (wr_go && wr_ok(idx, wd)) begin
      unique case (idx)
        `SSB_IDX_FAULT2: r_next.cfg.fault2_sel = wd;
        `SSB_IDX_OVT: r_next.cfg.ovt_sel = wd;
        `SSB_IDX_FAULT1: r_next.cfg.fault1_sel = wd;
        `SSB_IDX_PON: r_next.cfg.pon_ms = wd;
        `SSB_IDX_STILL: r_next.cfg.still_ms = wd;
        `SSB_IDX_THR: r_next.cfg.thr_rpm = wd;
        `SSB_IDX_ROTDLY: r_next.cfg.rot_ms = wd;
        `SSB_IDX_DISP: r_next.cfg.disp_sel = wd;
        `SSB_IDX_CTRL: r_next.cfg.ctrl = {15'h0000, wd[`SSB_CTRL_BRAKE_EN]};
        default: r_next.cfg = r_reg.cfg;
      endcase
    end
    // R18: fault display follows class-three fault when selected
    r_next.display = r_reg.pins.fault3 && r_reg.cfg.disp_sel[0];
    // Sequencer
    unique case (r_reg.st)
      ssb_pkg::SSB_S_OFF: begin
        // Energize on enable unless a stop event is pending
        if (r_reg.pins.servo_en && !evt) begin
          r_next.st = ssb_pkg::SSB_S_POWERUP;
          r_next.stage = 1'b1;
          r_next.brake = brake_en;
          r_next.plan = '{ssb_pkg::SSB_M_NONE, ssb_pkg::SSB_H_RUN};
          // R13: reference block timed from brake on
          tmr_start = 1'b1;
          tmr_limit = brake_en ? r_reg.cfg.pon_ms : 16'h0000;
        end
      end
      ssb_pkg::SSB_S_POWERUP: begin
        if (evt) begin
          r_next.st = ssb_pkg::SSB_S_STOPPING;
          r_next.plan = plan_new;
        end else if (tmr_done) begin
          // R13: references accepted after delay
          r_next.st = ssb_pkg::SSB_S_RUN;
        end
      end
      ssb_pkg::SSB_S_RUN: begin
        if (evt) begin
          r_next.st = ssb_pkg::SSB_S_STOPPING;
          r_next.plan = plan_new;
        end else if (!r_reg.pins.servo_en) begin
          if (!brake_en) begin
            // No brake sequencing: de-energize at once
            r_next.st = ssb_pkg::SSB_S_OFF;
          end else if (still) begin
            // R14: brake off, then wait before de-energizing
            r_next.st = ssb_pkg::SSB_S_STILL_WAIT;
            r_next.brake = 1'b0;
            tmr_start = 1'b1;
            tmr_limit = r_reg.cfg.still_ms;
          end else begin
            // R16: rotating, start disable delay
            r_next.st = ssb_pkg::SSB_S_ROT_WAIT;
            tmr_start = 1'b1;
            tmr_limit = r_reg.cfg.rot_ms;
          end
        end
      end
      ssb_pkg::SSB_S_STILL_WAIT: begin
        if (evt) begin
          r_next.st = ssb_pkg::SSB_S_STOPPING;
          r_next.plan = plan_new;
        end else if (tmr_done) begin
          // R14: de-energize after the delay
          r_next.st = ssb_pkg::SSB_S_OFF;
        end
      end
      ssb_pkg::SSB_S_ROT_WAIT: begin
        if (evt) begin
          r_next.st = ssb_pkg::SSB_S_STOPPING;
          r_next.plan = plan_new;
        // R15 R17: speed below threshold or delay, first wins
        end else if (slow || tmr_done) begin
          r_next.st = ssb_pkg::SSB_S_OFF;
          r_next.brake = 1'b0;
        end
      end
      ssb_pkg::SSB_S_STOPPING: begin
        // Brake engages while stopping; coast cuts power at once
        r_next.brake = 1'b0;
        r_next.stage = (r_reg.plan.method != ssb_pkg::SSB_M_COAST);
        if (still) begin
          r_next.st = ssb_pkg::SSB_S_HELD;
        end
      end
      ssb_pkg::SSB_S_HELD: begin
        // Only position lock keeps the stage energized
        r_next.stage = (r_reg.plan.hold == ssb_pkg::SSB_H_POSLOCK);
        if (!evt && !r_reg.pins.servo_en) begin
          r_next.st = ssb_pkg::SSB_S_OFF;
        end
      end
      default: r_next.st = ssb_pkg::SSB_S_OFF;
    endcase
    // Common outputs of the new state
    if (r_next.st == ssb_pkg::SSB_S_OFF) begin
      r_next.stage = 1'b0;
      r_next.brake = 1'b0;
      r_next.plan = '{ssb_pkg::SSB_M_NONE, ssb_pkg::SSB_H_DEENERG};
    end
    r_next.ref_block = (r_next.st != ssb_pkg::SSB_S_RUN);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      r_reg <= '0;
      r_reg.cfg <= '{`SSB_RST_FAULT2, `SSB_RST_OVT, `SSB_RST_FAULT1, `SSB_RST_PON,
                     `SSB_RST_STILL, `SSB_RST_THR, `SSB_RST_ROTDLY, `SSB_RST_DISP,
                     `SSB_RST_CTRL};
      r_reg.st <= ssb_pkg::SSB_S_OFF;
      r_reg.plan <= '{ssb_pkg::SSB_M_NONE, ssb_pkg::SSB_H_DEENERG};
      r_reg.ref_block <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from flops
  assign PRDATA_OUT = r_reg.prdata;
  assign PREADY_OUT = r_reg.pready;
  assign PSLVERR_OUT = r_reg.pslverr;
  assign HOLDING_BRAKE_OUTPUT_OUT = r_reg.brake;
  assign POWER_STAGE_ON_OUT = r_reg.stage;
  assign REF_BLOCK_OUT = r_reg.ref_block;
  assign STOP_METHOD_OUT = r_reg.plan.method;
  assign HOLD_STATE_OUT = r_reg.plan.hold;
  assign FAULT_DISPLAY_OUT = r_reg.display;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);

  a_pon_block_hold: assert property ( // R13
    r_reg.st == ssb_pkg::SSB_S_POWERUP && !tmr_done && !evt |=> REF_BLOCK_OUT && !$rose(r_reg.st == ssb_pkg::SSB_S_RUN)
  ) else $error("references released before power-on delay");

  a_still_energized: assert property ( // R14
    r_reg.st == ssb_pkg::SSB_S_STILL_WAIT && !tmr_done && !evt |=> POWER_STAGE_ON_OUT && !HOLDING_BRAKE_OUTPUT_OUT
  ) else $error("standstill delay cut short");

  a_rot_speed_off: assert property ( // R15
    r_reg.st == ssb_pkg::SSB_S_ROT_WAIT && slow && !evt |=> !HOLDING_BRAKE_OUTPUT_OUT && !POWER_STAGE_ON_OUT
  ) else $error("brake not off below speed threshold");

  a_rot_delay_off: assert property ( // R16
    r_reg.st == ssb_pkg::SSB_S_ROT_WAIT && tmr_done && !evt |=> r_reg.st == ssb_pkg::SSB_S_OFF
  ) else $error("brake not off after disable delay");

  a_ovt_forced: assert property ( // R09
    brake_en && ovt_live && !r_reg.pins.fault1 && !r_reg.pins.fault2 && r_reg.st == ssb_pkg::SSB_S_RUN
    |=> STOP_METHOD_OUT == 3'h4 && HOLD_STATE_OUT == 2'h3
  ) else $error("overtravel plan not forced");

  a_f1_forced: assert property ( // R11
    brake_en && r_reg.pins.fault1 && r_reg.st == ssb_pkg::SSB_S_RUN
    |=> STOP_METHOD_OUT == 3'h6 && HOLD_STATE_OUT == 2'h1
  ) else $error("class-one plan not forced");

  a_ovt_ignored: assert property ( // R07
    r_reg.st == ssb_pkg::SSB_S_RUN && r_reg.pins.servo_en && r_reg.cfg.ovt_sel == 16'h0007 &&
    !r_reg.pins.fault1 && !r_reg.pins.fault2 |=> r_reg.st == ssb_pkg::SSB_S_RUN
  ) else $error("overtravel not ignored");

  a_display_follow: assert property ( // R18
    ##1 FAULT_DISPLAY_OUT == ($past(r_reg.pins.fault3) && $past(r_reg.cfg.disp_sel[0]))
  ) else $error("fault display mismatch");

  a_f2_range: assert property ( // R01
    wr_go && idx == `SSB_IDX_FAULT2 && ($signed(wd) > 16'sd3 || $signed(wd) < -16'sd5)
    |=> $stable(r_reg.cfg.fault2_sel)
  ) else $error("class-two selector took an out-of-range value");

endmodule : ssb_top

// ### tb/ssb_motor_model.sv
// Motor model: speed follows the run command, runs down otherwise
`timescale 1ns/1ps
module ssb_motor_model (
  input wire logic clk_in,
  input wire logic run_in,
  input wire logic [15:0] target_in,
  output logic [15:0] speed_out
);
  // Loses 64 RPM a cycle when not driven
  always_ff @(posedge clk_in) begin
    if (run_in) speed_out <= target_in;
    else speed_out <= (speed_out > 16'h0040) ? speed_out - 16'h0040 : 16'h0000;
  end
endmodule : ssb_motor_model

// ### tb/tb_top.sv
// Bench of the stop and brake sequencer
`timescale 1ns/1ps
`define CHK(n, e, s) chk(n, 32'(e), 32'(s))
`define WT(s, v) for (t = 0; s !== v; t++) @(negedge clk)
module tb_top;
  logic clk, rst, psel, pen, pwr, pready, pslverr, sen, ovt, f1, f2, f3, run, brk, stg, refb, disp, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] spd, tgt, v;
  logic [4:0] plan;
  int fail_count = 0, n_tests = 0, cyc = 0, t;
  // Index, reset value and accepted bounds of each setting
  logic [7:0] ix[8] = '{8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h10};
  logic [15:0] rv[8] = '{16'h0002, 16'h0001, 16'h0002, 16'h00FA, 16'h0096, 16'h001E, 16'h01F4, 16'h0000};
  logic [15:0] lo[8] = '{16'hFFFB, 16'h0000, 16'h0000, 16'h0000, 16'h0032, 16'h0014, 16'h0001, 16'h0000};
  logic [15:0] hi[8] = '{16'h0003, 16'h0007, 16'h0002, 16'h01F4, 16'h03E8, 16'h0BB8, 16'h03E8, 16'h0001};
  // Stop plans, method over hold: overtravel, class one, class two
  logic [4:0] pt[20] = '{5'h05, 5'h0B, 5'h09, 5'h11, 5'h13, 5'h19, 5'h1A, 5'h00, 5'h05, 5'h19, 5'h1A,
    5'h0A, 5'h0E, 5'h12, 5'h16, 5'h1A, 5'h05, 5'h15, 5'h11, 5'h0D};
  ssb_top #(.CYC_PER_MS(17'd10)) dut (.MCLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .SERVO_ENABLE_IN(sen), .OVERTRAVEL_IN(ovt), .FAULT1_IN(f1), .FAULT2_IN(f2),
    .FAULT3_IN(f3), .MOTOR_SPEED_IN(spd), .HOLDING_BRAKE_OUTPUT_OUT(brk), .POWER_STAGE_ON_OUT(stg),
    .REF_BLOCK_OUT(refb), .STOP_METHOD_OUT(plan[4:2]), .HOLD_STATE_OUT(plan[1:0]), .FAULT_DISPLAY_OUT(disp));
  ssb_motor_model motor (.clk_in(clk), .run_in(run), .target_in(tgt), .speed_out(spd));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  // One APB transfer; read data and error land in q and err
  task automatic apb(input logic w, input logic [7:0] i, input logic [15:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge clk);
    pen <= 1'b1;
    // Hold the access until pready is seen high at a rising edge
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  // Brake function overrides every selector
  function automatic logic [4:0] exp_plan(input int p, input int c, input logic b);
    if (b) return (p == 0) ? 5'h13 : (p == 1) ? 5'h19 : 5'h12;
    return pt[(p == 0) ? c : (p == 1) ? c + 8 : c + 16];
  endfunction : exp_plan
  // Run up, raise one stop event while turning, check the plan, then release
  task automatic stop_case(input int p, input int c, input logic b);
    apb(1'b1, (p == 0) ? 8'h08 : (p == 1) ? 8'h09 : 8'h07, 16'(c));
    tgt <= 16'h03E8;
    run <= 1'b1;
    sen <= 1'b1;
    `WT(refb, 1'b0);
    @(posedge clk);
    run <= 1'b0;
    {f2, f1, ovt} <= 3'(1 << p);
    repeat (7) @(negedge clk);
    `CHK("stop plan", exp_plan(p, c, b), plan);
    @(posedge clk);
    {f2, f1, ovt, sen} <= 4'h0;
    repeat (40) @(posedge clk);
  endtask : stop_case
  // Cycle ceiling against a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      complete_run;
    end
  end
  initial begin
    {rst, psel, pen, pwr, sen, ovt, f1, f2, f3, run} = 10'h201;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    tgt = 16'h0000;
    v = 16'($urandom(32'h525965c8));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK("reset outputs", 8'h84, {refb, plan, brk, stg});
    // Defaults, random legal value, refused value above range
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, ix[i], 16'h0000);
      `CHK("reset value", rv[i], q);
      v = 16'(lo[i] + $urandom % 32'(16'(hi[i] - lo[i] + 16'h0001)));
      apb(1'b1, ix[i], v);
      apb(1'b1, ix[i], hi[i] + 16'h0001);
      apb(1'b0, ix[i], 16'h0000);
      `CHK("setting", v, q);
      apb(1'b1, ix[i], rv[i]);
    end
    apb(1'b0, 8'h20, 16'h0000);
    `CHK("unmapped", 1'b1, err);
    $display("register test done");
    apb(1'b1, 8'h10, 16'h0001);
    f3 <= 1'b1;
    repeat (6) @(negedge clk);
    `CHK("fault display", 1'b1, disp);
    apb(1'b1, 8'h10, 16'h0000);
    repeat (6) @(negedge clk);
    `CHK("display off", 1'b0, disp);
    @(posedge clk);
    f3 <= 1'b0;
    $display("display test done");
    // Every selector code, host includes lock codes for a vertical axis
    for (int c = 0; c < 8; c++) stop_case(0, c, 1'b0);
    for (int c = 0; c < 3; c++) stop_case(1, c, 1'b0);
    for (int c = -5; c < 4; c++) stop_case(2, c, 1'b0);
    $display("stop code test done");
    apb(1'b1, 8'h30, 16'h0001);
    apb(1'b1, 8'h0A, 16'h0005);
    apb(1'b1, 8'h0B, 16'h0032);
    tgt <= 16'h0000;
    sen <= 1'b1;
    `WT(brk, 1'b1);
    `WT(refb, 1'b0);
    `CHK("power-on block", 1'b1, t >= 49 && t <= 52);
    @(posedge clk);
    sen <= 1'b0;
    `WT(brk, 1'b0);
    `WT(stg, 1'b0);
    `CHK("standstill delay", 1'b1, t >= 499 && t <= 502);
    @(posedge clk);
    tgt <= 16'h03E8;
    run <= 1'b1;
    sen <= 1'b1;
    `WT(refb, 1'b0);
    @(posedge clk);
    sen <= 1'b0;
    run <= 1'b0;
    `WT(brk, 1'b0);
    `CHK("brake off speed", 1'b1, spd < 16'h001E && stg === 1'b0);
    apb(1'b1, 8'h0D, 16'h0001);
    run <= 1'b1;
    sen <= 1'b1;
    `WT(refb, 1'b0);
    @(posedge clk);
    sen <= 1'b0;
    `WT(brk, 1'b0);
    // Ten cycles of delay plus pin filter, state change and timer expiry
    `CHK("rotating delay", 1'b1, t >= 15 && t <= 18);
    $display("brake timing test done");
    for (int p = 0; p < 3; p++) stop_case(p, 0, 1'b1);
    $display("forced stop test done");
    complete_run;
  end
endmodule : tb_top
